// ---- logic/pcib_pkg.sv ----
// Shared constants and types for the PCI address/data and command port.
package pcib_pkg;
  // ===========================================================================
  // Widths and field positions
  localparam int AD_W = 64;
  localparam int LO_W = 32;
  localparam int CBE_W = 8;
  localparam int CMD_W = 4;
  localparam int CMD_WR_BIT = 0;
  // ===========================================================================
  // Reset values and timing counts
  localparam logic [AD_W-1:0] AD_RST = 64'h0;
  localparam logic [CBE_W-1:0] CBE_RST = 8'hff;
  localparam logic [LO_W-1:0] HI_ZERO = 32'h0;
  localparam logic [3:0] HI_BE_OFF = 4'hf;
  // PCI clocks a data phase may wait for the target before giving up.
  localparam logic [4:0] TRDY_WAIT_CYC = 5'h10;
  // ===========================================================================
  // Initiator sequencer states
  typedef enum logic [1:0] {
    PCIB_IDLE,
    PCIB_ADDR,
    PCIB_DATA,
    PCIB_TURN
  } pcib_st_t;
endpackage : pcib_pkg

// ---- logic/pcib_snoop_if.sv ----
// Bus view and captured-transfer record passed between the port and snooper.
`timescale 1ns/1ps
interface pcib_snoop_if;
  import pcib_pkg::*;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic req64_n;
  logic ack64_n;
  logic [AD_W-1:0] ad;
  logic [CBE_W-1:0] cbe;
  logic ev_tog;
  logic [LO_W-1:0] ev_addr;
  logic [CMD_W-1:0] ev_cmd;
  logic [AD_W-1:0] ev_data;
  logic [CBE_W-1:0] ev_be;
  logic ev_wide;
  modport top (output frame_n, irdy_n, trdy_n, req64_n, ack64_n, ad, cbe,
               input ev_tog, ev_addr, ev_cmd, ev_data, ev_be, ev_wide);
  modport snoop (input frame_n, irdy_n, trdy_n, req64_n, ack64_n, ad, cbe,
                 output ev_tog, ev_addr, ev_cmd, ev_data, ev_be, ev_wide);
endinterface : pcib_snoop_if

// ---- logic/pcib_snoop.sv ----
// Bus snooper: records address, command and every completed data phase.
`timescale 1ns/1ps
module pcib_snoop (
  input wire logic pci_clk, // PCI bus clock
  input wire logic pci_rst_n, // Reset synchronised to pci_clk
  pcib_snoop_if.snoop sn // Pin view in, transfer record out
);
  import pcib_pkg::*;
  logic prev_idle_reg;
  logic in_txn_reg;
  logic wide_req_reg;
  logic tog_reg;
  logic [LO_W-1:0] addr_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic [AD_W-1:0] data_reg;
  logic [CBE_W-1:0] be_reg;
  logic wide_reg;
  logic addr_phase;
  logic xfer;
  logic wide_ok;

  // ===========================================================================
  // Phase detection
  assign addr_phase = !sn.frame_n && prev_idle_reg;
  assign xfer = in_txn_reg && !sn.irdy_n && !sn.trdy_n;
  assign wide_ok = wide_req_reg && !sn.ack64_n;

  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      prev_idle_reg <= 1'b1;
      in_txn_reg <= 1'b0;
    end else begin
      prev_idle_reg <= sn.frame_n && sn.irdy_n;
      if (addr_phase) begin
        in_txn_reg <= 1'b1;
      end else if (sn.frame_n && sn.irdy_n) begin
        in_txn_reg <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Address phase capture
  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      addr_reg <= HI_ZERO;
      cmd_reg <= '0;
      wide_req_reg <= 1'b0;
    end else if (addr_phase) begin
      addr_reg <= sn.ad[LO_W-1:0];
      cmd_reg <= sn.cbe[CMD_W-1:0];
      wide_req_reg <= !sn.req64_n;
    end
  end

  // ===========================================================================
  // Data phase capture; the high half counts only on a 64-bit transfer.
  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      tog_reg <= 1'b0;
      data_reg <= AD_RST;
      be_reg <= '0;
      wide_reg <= 1'b0;
    end else if (xfer) begin
      tog_reg <= !tog_reg;
      data_reg <= {wide_ok ? sn.ad[AD_W-1:LO_W] : HI_ZERO,
                   sn.ad[LO_W-1:0]};
      be_reg <= {wide_ok ? ~sn.cbe[CBE_W-1:4] : 4'h0,
                 ~sn.cbe[3:0]};
      wide_reg <= wide_ok;
    end
  end

  assign sn.ev_tog = tog_reg;
  assign sn.ev_addr = addr_reg;
  assign sn.ev_cmd = cmd_reg;
  assign sn.ev_data = data_reg;
  assign sn.ev_be = be_reg;
  assign sn.ev_wide = wide_reg;

  // ===========================================================================
  // Checks
  property p_snoop_addr;
    @(posedge pci_clk) disable iff (!pci_rst_n)
    addr_phase |=> addr_reg == $past(sn.ad[LO_W-1:0]) &&
                   cmd_reg == $past(sn.cbe[CMD_W-1:0]);
  endproperty
  a_snoop_addr: assert property (p_snoop_addr) else $error("addr lost");
  property p_snoop_wait;
    @(posedge pci_clk) disable iff (!pci_rst_n)
    (sn.irdy_n || sn.trdy_n) |=> $stable(tog_reg);
  endproperty
  a_snoop_wait: assert property (p_snoop_wait) else $error("wait moved");
  property p_snoop_upper;
    @(posedge pci_clk) disable iff (!pci_rst_n)
    $changed(tog_reg) && !wide_reg |-> be_reg[CBE_W-1:4] == 4'h0;
  endproperty
  a_snoop_upper: assert property (p_snoop_upper) else $error("upper be");
endmodule : pcib_snoop

// ---- logic/pcib_pci_port.sv ----
// PCI address/data and command port: initiator, snooper crossing, straps.
`timescale 1ns/1ps
module pcib_pci_port (
  input wire logic clock, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic pci_clk, // PCI bus clock
  input wire logic req_valid, // Start one transaction
  output logic req_ready, // Port idle, request accepted when high
  input wire logic [pcib_pkg::CMD_W-1:0] req_cmd, // Bus command code
  input wire logic [pcib_pkg::LO_W-1:0] req_addr, // Bus address
  input wire logic [pcib_pkg::AD_W-1:0] req_data, // Write data
  input wire logic [pcib_pkg::CBE_W-1:0] req_be, // Byte enables, active high
  input wire logic req_wide, // Ask for a 64-bit transfer
  output logic done_valid, // Transaction ended, one-cycle pulse
  output logic [pcib_pkg::AD_W-1:0] done_rdata, // Read data
  output logic done_wide, // Target accepted 64-bit width
  output logic done_abort, // Target never became ready
  output logic mon_valid, // Snooped data phase, one-cycle pulse
  output logic [pcib_pkg::LO_W-1:0] mon_addr, // Snooped address
  output logic [pcib_pkg::CMD_W-1:0] mon_cmd, // Snooped command
  output logic [pcib_pkg::AD_W-1:0] mon_data, // Snooped data
  output logic [pcib_pkg::CBE_W-1:0] mon_be, // Snooped byte enables
  output logic mon_wide, // Snooped phase was 64-bit
  output logic [pcib_pkg::LO_W-1:0] strap_ad, // Address/data straps
  output logic [pcib_pkg::CBE_W-1:0] strap_cbe, // Command line straps
  input wire logic [pcib_pkg::AD_W-1:0] ad_in, // Address/data pin level
  output logic [pcib_pkg::AD_W-1:0] ad_out, // Address/data drive value
  output logic [1:0] ad_oe, // Drive enable, bit 0 low half, bit 1 high
  input wire logic [pcib_pkg::CBE_W-1:0] cbe_in, // Command/enable pin level
  output logic [pcib_pkg::CBE_W-1:0] cbe_out, // Command/enable drive value
  output logic [1:0] cbe_oe, // Drive enable, bit 0 low four, bit 1 high
  input wire logic frame_n_in, // Frame pin level
  output logic frame_n_out, // Frame drive value
  output logic frame_n_oe, // Frame drive enable
  input wire logic irdy_n_in, // Initiator ready pin level
  output logic irdy_n_out, // Initiator ready drive value
  output logic irdy_n_oe, // Initiator ready drive enable
  input wire logic trdy_n_in, // Target ready pin level
  input wire logic req64_n_in, // 64-bit request pin level
  output logic req64_n_out, // 64-bit request drive value
  output logic req64_n_oe, // 64-bit request drive enable
  input wire logic ack64_n_in // 64-bit acknowledge pin level
);
  import pcib_pkg::*;
  pcib_snoop_if sn ();
  pcib_st_t state_reg;
  logic rst_m_reg, rst_s_reg;
  logic ready_reg, req_tog_reg, wide_h_reg;
  logic [CMD_W-1:0] cmd_h_reg;
  logic [LO_W-1:0] addr_h_reg;
  logic [AD_W-1:0] data_h_reg;
  logic [CBE_W-1:0] be_h_reg;
  logic rq_s1_reg, rq_s2_reg, rq_s3_reg;
  logic dn_s1_reg, dn_s2_reg, dn_s3_reg;
  logic mn_s1_reg, mn_s2_reg, mn_s3_reg;
  logic done_tog_reg, abort_reg, wide_ok_reg;
  logic [AD_W-1:0] rdata_reg;
  logic [4:0] wait_reg;
  logic start, finish, timeout, done_ev, mon_ev;

  // ===========================================================================
  // System clock side: request hold and response/monitor crossings
  assign done_ev = dn_s2_reg ^ dn_s3_reg;
  assign mon_ev = mn_s2_reg ^ mn_s3_reg;
  assign req_ready = ready_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ready_reg <= 1'b1;
      req_tog_reg <= 1'b0;
    end else if (req_valid && ready_reg) begin
      ready_reg <= 1'b0;
      req_tog_reg <= !req_tog_reg;
    end else if (done_ev) begin
      ready_reg <= 1'b1;
    end
  end

  // Held words stay still until the PCI side reports completion.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmd_h_reg <= '0;
      addr_h_reg <= HI_ZERO;
      data_h_reg <= AD_RST;
      be_h_reg <= '0;
      wide_h_reg <= 1'b0;
    end else if (req_valid && ready_reg) begin
      cmd_h_reg <= req_cmd;
      addr_h_reg <= req_addr;
      data_h_reg <= req_data;
      be_h_reg <= req_be;
      wide_h_reg <= req_wide;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      {dn_s1_reg, dn_s2_reg, dn_s3_reg} <= 3'h0;
      {mn_s1_reg, mn_s2_reg, mn_s3_reg} <= 3'h0;
    end else begin
      {dn_s1_reg, dn_s2_reg, dn_s3_reg} <= {done_tog_reg, dn_s1_reg, dn_s2_reg};
      {mn_s1_reg, mn_s2_reg, mn_s3_reg} <= {sn.ev_tog, mn_s1_reg, mn_s2_reg};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      done_valid <= 1'b0;
      done_rdata <= AD_RST;
      done_wide <= 1'b0;
      done_abort <= 1'b0;
    end else begin
      done_valid <= done_ev;
      if (done_ev) begin
        done_rdata <= rdata_reg;
        done_wide <= wide_ok_reg;
        done_abort <= abort_reg;
      end
    end
  end

  // A burst faster than the toggle crossing shows only its latest word.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mon_valid <= 1'b0;
      mon_addr <= HI_ZERO;
      mon_cmd <= '0;
      mon_data <= AD_RST;
      mon_be <= '0;
      mon_wide <= 1'b0;
    end else begin
      mon_valid <= mon_ev;
      if (mon_ev) begin
        mon_addr <= sn.ev_addr;
        mon_cmd <= sn.ev_cmd;
        mon_data <= sn.ev_data;
        mon_be <= sn.ev_be;
        mon_wide <= sn.ev_wide;
      end
    end
  end

  // ===========================================================================
  // PCI side: reset, straps, request crossing
  always_ff @(posedge pci_clk) begin
    rst_m_reg <= nrst;
    rst_s_reg <= rst_m_reg;
  end

  // Pins are released in reset so the pull resistors set the strap levels.
  always_ff @(posedge pci_clk) begin
    if (!rst_s_reg) begin
      strap_ad <= ad_in[LO_W-1:0];
      strap_cbe <= cbe_in;
    end
  end

  always_ff @(posedge pci_clk) begin
    if (!rst_s_reg) begin
      {rq_s1_reg, rq_s2_reg, rq_s3_reg} <= 3'h0;
    end else begin
      {rq_s1_reg, rq_s2_reg, rq_s3_reg} <= {req_tog_reg, rq_s1_reg, rq_s2_reg};
    end
  end

  assign start = (state_reg == PCIB_IDLE) && (rq_s2_reg ^ rq_s3_reg);
  assign finish = (state_reg == PCIB_DATA) && !trdy_n_in;
  assign timeout = (state_reg == PCIB_DATA) && (wait_reg == TRDY_WAIT_CYC);

  // ===========================================================================
  // Initiator sequencer: one address phase, one data phase, turnaround
  always_ff @(posedge pci_clk) begin
    if (!rst_s_reg) begin
      state_reg <= PCIB_IDLE;
      wait_reg <= 5'h0;
    end else begin
      case (state_reg)
        PCIB_IDLE: begin
          if (start) begin
            state_reg <= PCIB_ADDR;
          end
        end
        PCIB_ADDR: begin
          state_reg <= PCIB_DATA;
          wait_reg <= 5'h0;
        end
        PCIB_DATA: begin
          if (finish || timeout) begin
            state_reg <= PCIB_TURN;
          end
          wait_reg <= wait_reg + 5'h1;
        end
        PCIB_TURN: state_reg <= PCIB_IDLE;
        default: state_reg <= PCIB_IDLE;
      endcase
    end
  end

  always_ff @(posedge pci_clk) begin
    if (!rst_s_reg) begin
      ad_out <= AD_RST;
      ad_oe <= 2'b00;
      cbe_out <= CBE_RST;
      cbe_oe <= 2'b00;
      frame_n_out <= 1'b1;
      frame_n_oe <= 1'b0;
      irdy_n_out <= 1'b1;
      irdy_n_oe <= 1'b0;
      req64_n_out <= 1'b1;
      req64_n_oe <= 1'b0;
    end else begin
      case (state_reg)
        PCIB_IDLE: begin
          if (start) begin
            frame_n_out <= 1'b0;
            frame_n_oe <= 1'b1;
            irdy_n_oe <= 1'b1;
            req64_n_out <= !wide_h_reg;
            req64_n_oe <= 1'b1;
            ad_out <= {HI_ZERO, addr_h_reg};
            ad_oe <= {wide_h_reg, 1'b1};
            cbe_out <= {HI_BE_OFF, cmd_h_reg};
            cbe_oe <= {wide_h_reg, 1'b1};
          end
        end
        PCIB_ADDR: begin
          frame_n_out <= 1'b1;
          req64_n_out <= 1'b1;
          irdy_n_out <= 1'b0;
          ad_out <= data_h_reg;
          if (cmd_h_reg[CMD_WR_BIT]) begin
            ad_oe <= {wide_h_reg, 1'b1};
          end else begin
            ad_oe <= 2'b00;
          end
          cbe_out <= ~be_h_reg;
        end
        PCIB_DATA: begin
          if (finish || timeout) begin
            irdy_n_out <= 1'b1;
            ad_oe <= 2'b00;
            cbe_oe <= 2'b00;
          end
        end
        PCIB_TURN: begin
          frame_n_oe <= 1'b0;
          irdy_n_oe <= 1'b0;
          req64_n_oe <= 1'b0;
        end
        default: frame_n_oe <= 1'b0;
      endcase
    end
  end

  // Read data counts only in the clock where the target is ready.
  always_ff @(posedge pci_clk) begin
    if (!rst_s_reg) begin
      rdata_reg <= AD_RST;
      wide_ok_reg <= 1'b0;
      abort_reg <= 1'b0;
      done_tog_reg <= 1'b0;
    end else if (finish) begin
      wide_ok_reg <= wide_h_reg && !ack64_n_in;
      rdata_reg <= {(wide_h_reg && !ack64_n_in) ? ad_in[AD_W-1:LO_W]
                    : HI_ZERO, ad_in[LO_W-1:0]};
      abort_reg <= 1'b0;
      done_tog_reg <= !done_tog_reg;
    end else if (timeout) begin
      abort_reg <= 1'b1;
      wide_ok_reg <= 1'b0;
      done_tog_reg <= !done_tog_reg;
    end
  end

  // ===========================================================================
  // Snooper on the shared pins
  assign sn.frame_n = frame_n_in;
  assign sn.irdy_n = irdy_n_in;
  assign sn.trdy_n = trdy_n_in;
  assign sn.req64_n = req64_n_in;
  assign sn.ack64_n = ack64_n_in;
  assign sn.ad = ad_in;
  assign sn.cbe = cbe_in;

  pcib_snoop u_snoop (
    .pci_clk(pci_clk),
    .pci_rst_n(rst_s_reg),
    .sn(sn)
  );

  // ===========================================================================
  // Checks
  sequence s_start;
    start;
  endsequence
  sequence s_addr_out;
    !frame_n_out && frame_n_oe && ad_oe[0] && ad_out[LO_W-1:0] == addr_h_reg;
  endsequence
  property p_frame_addr;
    @(posedge pci_clk) disable iff (!rst_s_reg) s_start |=> s_addr_out;
  endproperty
  a_frame_addr: assert property (p_frame_addr) else $error("no addr");
  property p_one_addr;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    s_start |=> s_addr_out ##1 (frame_n_out && !irdy_n_out && irdy_n_oe);
  endproperty
  a_one_addr: assert property (p_one_addr) else $error("addr phase");
  property p_cmd_out;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    s_start |=> cbe_out[CMD_W-1:0] == cmd_h_reg && cbe_oe[0];
  endproperty
  a_cmd_out: assert property (p_cmd_out) else $error("cmd");
  property p_be_out;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    state_reg == PCIB_ADDR |=> cbe_out == ~be_h_reg && !irdy_n_out;
  endproperty
  a_be_out: assert property (p_be_out) else $error("byte enables");
  property p_req64;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    s_start |=> req64_n_oe && (req64_n_out == !wide_h_reg);
  endproperty
  a_req64: assert property (p_req64) else $error("req64");
  property p_xfer_end;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    finish |=> state_reg == PCIB_TURN && irdy_n_out && $changed(done_tog_reg);
  endproperty
  a_xfer_end: assert property (p_xfer_end) else $error("xfer end");
  property p_narrow;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    finish && ack64_n_in |=> rdata_reg[AD_W-1:LO_W] == HI_ZERO && !wide_ok_reg;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper half");
  property p_strap_cap;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    $rose(rst_s_reg) |-> strap_ad == $past(ad_in[LO_W-1:0]) &&
                         strap_cbe == $past(cbe_in);
  endproperty
  a_strap_cap: assert property (p_strap_cap) else $error("strap");
  property p_strap_hold;
    @(posedge pci_clk) disable iff (!rst_s_reg)
    $past(rst_s_reg) |-> $stable(strap_ad) && $stable(strap_cbe);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
endmodule : pcib_pci_port

// ---- dv/pcib_tgt_model.sv ----
// Behavioural PCI target that answers the port's transactions.
`timescale 1ns/1ps
module pcib_tgt_model (
  input wire logic pci_clk, // PCI bus clock
  input wire logic nrst, // Reset, active low
  input wire logic frame_n, // Resolved frame level
  input wire logic irdy_n, // Resolved initiator ready level
  input wire logic req64_n, // Resolved 64-bit request level
  input wire logic [63:0] ad, // Resolved address/data level
  input wire logic [7:0] cbe, // Resolved command/enable level
  input wire logic ack_en, // Accept 64-bit requests
  input wire logic stall, // Never become ready
  input wire logic [3:0] waits, // Wait states before ready
  input wire logic [63:0] rd_word, // Data returned on reads
  output logic trdy_n, // Target ready drive value
  output logic ack64_n, // 64-bit acknowledge drive value
  output logic tgt_oe, // Drives trdy and ack64 when high
  output logic [63:0] ad_drv, // Read data drive value
  output logic [1:0] ad_drv_oe, // Read data drive enables
  output logic [31:0] cap_addr, // Last address seen
  output logic [3:0] cap_cmd, // Last command seen
  output logic [63:0] cap_data, // Last transferred word
  output logic [7:0] cap_be, // Last byte enables, active high
  output logic [7:0] n_addr, // Address phases seen
  output logic [7:0] n_xfer // Words transferred
);
  logic busy_reg;
  logic wide_reg;
  logic idle_reg;
  logic [3:0] cnt_reg;
  // ===========================================================================
  // Target sequencer
  // All pins are looked at only on the rising PCI clock edge.
  always_ff @(posedge pci_clk) begin
    idle_reg <= frame_n && irdy_n;
    if (!nrst) begin
      busy_reg <= 1'b0;
      tgt_oe <= 1'b0;
      trdy_n <= 1'b1;
      ack64_n <= 1'b1;
      ad_drv_oe <= 2'h0;
      ad_drv <= 64'h0;
      n_addr <= 8'h0;
      n_xfer <= 8'h0;
    end else if (!busy_reg && !frame_n && idle_reg) begin
      busy_reg <= 1'b1;
      cap_addr <= ad[31:0];
      cap_cmd <= cbe[3:0];
      n_addr <= n_addr + 8'h1;
      wide_reg <= !req64_n && ack_en;
      ack64_n <= !(!req64_n && ack_en);
      tgt_oe <= 1'b1;
      cnt_reg <= 4'h0;
    end else if (busy_reg && !irdy_n && !trdy_n) begin
      cap_data <= wide_reg ? ad : {32'h0, ad[31:0]};
      cap_be <= ~cbe & (wide_reg ? 8'hff : 8'h0f);
      n_xfer <= n_xfer + 8'h1;
      busy_reg <= 1'b0;
      trdy_n <= 1'b1;
      ack64_n <= 1'b1;
      ad_drv_oe <= 2'h0;
    end else if (busy_reg && frame_n && irdy_n) begin
      // The initiator gave up; let go of everything at once.
      busy_reg <= 1'b0;
      tgt_oe <= 1'b0;
      trdy_n <= 1'b1;
      ack64_n <= 1'b1;
      ad_drv_oe <= 2'h0;
    end else if (busy_reg && !stall && trdy_n && cnt_reg == waits) begin
      trdy_n <= 1'b0;
      if (!cap_cmd[0]) begin
        ad_drv <= rd_word;
        ad_drv_oe <= {wide_reg, 1'b1};
      end
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else begin
      tgt_oe <= 1'b0;
    end
  end
endmodule : pcib_tgt_model

// ---- dv/test_pci_ad_cbe_interface.sv ----
// Self-checking bench for the PCI address/data and command port.
`timescale 1ns/1ps
module test_pci_ad_cbe_interface;
  import pcib_pkg::*;
  localparam logic [31:0] PULL_AD = 32'h5a3c96e1;
  localparam logic [31:0] PULL_HI = 32'hc3e10f78;
  localparam logic [7:0] PULL_CBE = 8'ha5;
  localparam logic [63:0] RD_WORD = 64'h1f2e3d4c5b6a7988;
  logic clock, nrst, pci_clk, req_valid, req_ready, req_wide;
  logic [3:0] req_cmd;
  logic [31:0] req_addr, mon_addr, strap_ad, cap_addr;
  logic [63:0] req_data, done_rdata, mon_data, ad_out, ad_lvl, tgt_ad;
  logic [63:0] cap_data;
  logic [7:0] req_be, mon_be, strap_cbe, cbe_out, cbe_lvl, cap_be;
  logic [7:0] n_addr, n_xfer;
  logic done_valid, done_wide, done_abort, mon_valid, mon_wide;
  logic [3:0] mon_cmd, cap_cmd, waits;
  logic [1:0] ad_oe, cbe_oe, tgt_aoe;
  logic frame_n_out, frame_n_oe, irdy_n_out, irdy_n_oe, req64_n_out;
  logic req64_n_oe, trdy_drv, ack64_drv, tgt_oe, ack_en, stall;
  int err_count = 0;
  int samples_checked = 0;
  // ===========================================================================
  // Pin resolution with the strap pull network on released lines
  assign ad_lvl[31:0] = ad_oe[0] ? ad_out[31:0] :
                        tgt_aoe[0] ? tgt_ad[31:0] : PULL_AD;
  assign ad_lvl[63:32] = ad_oe[1] ? ad_out[63:32] :
                         tgt_aoe[1] ? tgt_ad[63:32] : PULL_HI;
  assign cbe_lvl[3:0] = cbe_oe[0] ? cbe_out[3:0] : PULL_CBE[3:0];
  assign cbe_lvl[7:4] = cbe_oe[1] ? cbe_out[7:4] : PULL_CBE[7:4];
  pcib_pci_port pcib_pci_port_inst (.clock(clock), .nrst(nrst),
    .pci_clk(pci_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
    .req_be(req_be), .req_wide(req_wide), .done_valid(done_valid),
    .done_rdata(done_rdata), .done_wide(done_wide),
    .done_abort(done_abort), .mon_valid(mon_valid), .mon_addr(mon_addr),
    .mon_cmd(mon_cmd), .mon_data(mon_data), .mon_be(mon_be),
    .mon_wide(mon_wide), .strap_ad(strap_ad), .strap_cbe(strap_cbe),
    .ad_in(ad_lvl), .ad_out(ad_out), .ad_oe(ad_oe), .cbe_in(cbe_lvl),
    .cbe_out(cbe_out), .cbe_oe(cbe_oe),
    .frame_n_in(frame_n_oe ? frame_n_out : 1'b1),
    .frame_n_out(frame_n_out), .frame_n_oe(frame_n_oe),
    .irdy_n_in(irdy_n_oe ? irdy_n_out : 1'b1), .irdy_n_out(irdy_n_out),
    .irdy_n_oe(irdy_n_oe), .trdy_n_in(tgt_oe ? trdy_drv : 1'b1),
    .req64_n_in(req64_n_oe ? req64_n_out : 1'b1),
    .req64_n_out(req64_n_out), .req64_n_oe(req64_n_oe),
    .ack64_n_in(tgt_oe ? ack64_drv : 1'b1));
  pcib_tgt_model pcib_tgt_model_inst (.pci_clk(pci_clk), .nrst(nrst),
    .frame_n(frame_n_oe ? frame_n_out : 1'b1),
    .irdy_n(irdy_n_oe ? irdy_n_out : 1'b1),
    .req64_n(req64_n_oe ? req64_n_out : 1'b1), .ad(ad_lvl),
    .cbe(cbe_lvl), .ack_en(ack_en), .stall(stall), .waits(waits),
    .rd_word(RD_WORD), .trdy_n(trdy_drv), .ack64_n(ack64_drv),
    .tgt_oe(tgt_oe), .ad_drv(tgt_ad), .ad_drv_oe(tgt_aoe),
    .cap_addr(cap_addr), .cap_cmd(cap_cmd), .cap_data(cap_data),
    .cap_be(cap_be), .n_addr(n_addr), .n_xfer(n_xfer));
  // ===========================================================================
  // Checking helpers
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // One whole transaction; expectations follow from the arguments alone.
  task automatic run_txn(input logic [3:0] cmd, input logic [31:0] addr,
    input logic [63:0] data, input logic [7:0] be, input logic wide,
    input logic acc, input logic [3:0] w, input logic stl);
    logic wx, seen;
    logic [7:0] na, nx, bex;
    logic [63:0] word;
    int i;
    wx = wide && acc;
    word = cmd[0] ? data : RD_WORD;
    if (!wx) word[63:32] = 32'h0;
    bex = wx ? be : {4'h0, be[3:0]};
    na = n_addr;
    nx = n_xfer;
    seen = 1'b0;
    ack_en <= acc;
    stall <= stl;
    waits <= w;
    req_cmd <= cmd;
    req_addr <= addr;
    req_data <= data;
    req_be <= be;
    req_wide <= wide;
    req_valid <= 1'b1;
    i = 0;
    // Status is looked at on the falling edge, where it has settled.
    @(negedge clock);
    while (req_ready !== 1'b1 && i < 400) begin
      @(negedge clock);
      i++;
    end
    @(posedge clock);
    req_valid <= 1'b0;
    do begin
      @(negedge clock);
      i++;
      if (mon_valid === 1'b1) seen = 1'b1;
    end while (done_valid !== 1'b1 && i < 800);
    @(posedge clock);
    if (i >= 400 && req_ready !== 1'b1 || i >= 800) begin
      err_count++;
      wrap_up();
    end
    repeat (8) @(posedge clock);
    chk(64'(seen), 64'(!stl));
    chk(64'(done_abort), 64'(stl));
    chk(64'(n_addr), 64'(na + 8'h1));
    if (!stl) begin
      chk(64'(n_xfer), 64'(nx + 8'h1));
      chk(64'(cap_addr), 64'(addr));
      chk(64'(cap_cmd), 64'(cmd));
      chk(64'(done_wide), 64'(wx));
      chk(64'(mon_addr), 64'(addr));
      chk(64'(mon_cmd), 64'(cmd));
      chk(mon_data, word);
      chk(64'(mon_be), 64'(bex));
      chk(64'(mon_wide), 64'(wx));
      if (cmd[0]) begin
        chk(cap_data, word);
        chk(64'(cap_be), 64'(bex));
      end else begin
        chk(done_rdata, word);
      end
    end
  endtask : run_txn
  // ===========================================================================
  // Scenarios
  task automatic t_straps();
    chk(64'(strap_ad), 64'(PULL_AD));
    chk(64'(strap_cbe), 64'(PULL_CBE));
  endtask : t_straps
  task automatic t_write_narrow();
    // Upper enables set on a narrow write must not reach the bus record.
    run_txn(4'h7, 32'h00c0_0010, 64'h8877665544332211, 8'hf5, 1'b0, 1'b1,
            4'h0, 1'b0);
  endtask : t_write_narrow
  task automatic t_read_wide_slow();
    run_txn(4'h6, 32'h0040_0100, 64'h0, 8'hff, 1'b1, 1'b1, 4'h3, 1'b0);
  endtask : t_read_wide_slow
  task automatic t_wide_refused();
    run_txn(4'hf, 32'h0080_0008, 64'hdeadbeef01234567, 8'hc3, 1'b1, 1'b0,
            4'h1, 1'b0);
  endtask : t_wide_refused
  task automatic t_write_wide();
    run_txn(4'hf, 32'h0080_0020, 64'h0a0b0c0d10203040, 8'h3c, 1'b1, 1'b1,
            4'h0, 1'b0);
  endtask : t_write_wide
  task automatic t_abort();
    run_txn(4'h7, 32'h0000_0200, 64'h55, 8'h0f, 1'b0, 1'b1, 4'h0, 1'b1);
  endtask : t_abort
  task automatic t_cmd_sweep();
    // Every command code, back to back, with varying target waits.
    for (int k = 0; k < 16; k++) begin
      run_txn(4'(k), 32'h2000_0000 | (32'(k) << 2), 64'h9a000000 | 64'(k),
              8'h0f, k[1], 1'b1, 4'(k % 3), 1'b0);
    end
  endtask : t_cmd_sweep
  // ===========================================================================
  // Clocks and main sequence
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    pci_clk = 1'b0;
    #3.3;
    forever #7.5 pci_clk = ~pci_clk;
  end
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_addr = 32'h0;
    req_data = 64'h0;
    req_be = 8'h0;
    req_wide = 1'b0;
    ack_en = 1'b1;
    stall = 1'b0;
    waits = 4'h0;
    // Reset must also span several PCI clocks, so it is held longer.
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (40) @(posedge clock);
    t_straps();
    t_write_narrow();
    t_read_wide_slow();
    t_wide_refused();
    t_write_wide();
    t_abort();
    t_cmd_sweep();
    t_straps();
    wrap_up();
  end
endmodule : test_pci_ad_cbe_interface
